// ==== arpsc_pkg.sv ====
// Shared constants and types for the converter reset and power control block
`default_nettype none
package arpsc_pkg;
  // Serial frame layout: bit 15 read flag, 14:8 address, 7:0 data
  localparam int          FRAME_BITS = 16;
  localparam logic [3:0]  LAST_BIT   = 4'hF;
  localparam int          RW_BIT     = 15;
  localparam int          ADDR_MSB   = 14;
  localparam int          ADDR_LSB   = 8;
  localparam int          DATA_MSB   = 7;
  // Register addresses
  localparam logic [6:0]  ADDR_STATUS  = 7'h02;
  localparam logic [6:0]  ADDR_CONTROL = 7'h04;
  localparam logic [6:0]  ADDR_MUX     = 7'h06;
  localparam logic [6:0]  ADDR_SECOND_CONFIG_REGISTER = 7'h07;
  localparam logic [6:0]  ADDR_CRC_LO  = 7'h12;
  localparam logic [6:0]  ADDR_CRC_HI  = 7'h13;
  // Control register value and bits
  localparam logic [7:0]  RESET_CODE = 8'h58;
  localparam int          CTL_START  = 0;
  localparam int          CTL_STOP   = 1;
  // Status bits
  localparam int          ST_POR = 0;
  localparam int          ST_ALV = 1;
  // Second configuration register fields and reset values
  localparam int          CFG_SPEED_LSB = 0;
  localparam int          CFG_MODE_LSB  = 2;
  localparam int          CFG_STBY      = 4;
  localparam int          CFG_POWER_OFF_BIT      = 5;
  localparam logic [7:0]  CFG2_RESET    = 8'h04;
  localparam logic [7:0]  MUX_RESET     = 8'h00;
  // Input synchroniser reset image: reset pin and chip select idle high
  localparam logic [10:0] SYNC_INIT = 11'h006;
  // Serial reset patterns
  localparam logic [10:0] PAT1_ONES = 11'h3FF;
  localparam logic [10:0] PAT2_ONES = 11'h400;
  // Timing
  localparam int          SYS_CLK_MHZ       = 10;
  localparam int          CONV_PERIOD_NS    = 2000;
  localparam int          FILTER_LAT_NS     = 7600;
  localparam logic [15:0] CONV_PERIOD_CYC   = 16'(CONV_PERIOD_NS * SYS_CLK_MHZ / 1000);
  localparam logic [15:0] FILTER_LAT_CYC    = 16'(FILTER_LAT_NS * SYS_CLK_MHZ / 1000);
  localparam logic [15:0] STBY_EXTRA_CYC    = 16'h0018;
  localparam logic [15:0] SYNC_WIN_CYC      = 16'h0001;
  // Conversion control modes
  typedef enum logic [1:0] {
    SM_SYNC    = 2'b00,
    SM_STSTOP  = 2'b01,
    SM_ONESHOT = 2'b10
  } arpsc_start_mode_t;
  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_STOP   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } arpsc_state_t;
endpackage
`default_nettype wire

// ==== arpsc_sync.sv ====
// Two-stage synchroniser for a group of asynchronous levels
`default_nettype none
module arpsc_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // Both stages load the idle image under reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= INIT;
      q      <= INIT;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== arpsc_ctrl.sv ====
// Reset, power-mode and conversion-start control of the converter core
`default_nettype none
module arpsc_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  input  wire logic       three_wire_mode,
  input  wire logic       start_pin,
  input  wire logic       reset_pin_n,
  input  wire logic [3:0] supply_low,
  output logic            sdo,
  output logic            conversion_ready_n,
  output logic [7:0]      second_config_register,
  output logic [7:0]      input_selector_register,
  output logic            por_flag,
  output logic            analog_undervoltage_flag,
  output logic            sampling_on,
  output logic            filter_active,
  output logic            standby_on,
  output logic            device_reset
);
  // Link-side frame state
  logic [15:0] sh_q;            // Shift register of received bits
  logic [3:0]  bit_q;           // Bit position in frame
  logic [10:0] ones_q;          // Run of consecutive ones
  logic        arm_q;           // Reset pending at select rise
  logic [6:0]  wr_addr_q;       // Last write address
  logic [7:0]  wr_data_q;       // Last write data
  logic        wr_tgl_q;        // Toggles per completed write other than the reset code
  logic        pat_tgl_q;       // Toggles per long-pattern reset
  logic        code_tgl_q;      // Toggles per three-wire code reset
  logic        tw_s;            // Wire mode, link-clock copy
  logic        frame_rst;       // Clears frame state
  logic [15:0] frame_w;         // Frame including current bit
  logic        wr_done;         // Write frame completes now
  logic        code_hit;        // That write carries the reset code
  // System-side synchronised inputs and edge history
  logic [10:0] sy_s;
  logic        start_s, rpin_s, cs_s, wr_s, pat_s, code_s, arm_s;
  logic [3:0]  sup_s;
  logic        start_p_q, cs_p_q, wr_p_q, pat_p_q, code_p_q, arm_d_q;
  logic        start_rise, cs_rise, wr_ev, pat_ev, code_ev;
  // Reset and registers
  logic        dev_rst_q;       // Pin, code or pattern reset
  logic        any_rst;         // Power-on or device reset
  logic [7:0]  cfg2_q;
  logic [7:0]  mux_q;
  logic        por_q, alv_q;
  logic        start_cmd_q, stop_cmd_q;
  logic        ss_run_q;        // Start/stop command latch
  logic        restart_q;       // Register write restarts conversion
  // Sequencer
  arpsc_pkg::arpsc_state_t      state_q;
  arpsc_pkg::arpsc_start_mode_t mode_w;
  logic [15:0] cnt_q;           // Cycles to next result
  logic [15:0] ph_q;            // Phase since last accepted sync
  logic        have_sync_q;     // A sync edge has been seen
  logic        conversion_ready_n_n_q;
  logic        power_off_bit_w, stby_w, trig_w, resync_w, go_w, done_w;
  logic [15:0] lat_w;

  assign frame_rst = cs_n | rst | dev_rst_q;
  assign frame_w   = {sh_q[14:0], sdi};
  assign wr_done   = (bit_q == arpsc_pkg::LAST_BIT) && !frame_w[arpsc_pkg::RW_BIT];
  assign code_hit  = wr_done
                   && (frame_w[arpsc_pkg::ADDR_MSB:arpsc_pkg::ADDR_LSB] == arpsc_pkg::ADDR_CONTROL)
                   && (frame_w[arpsc_pkg::DATA_MSB:0] == arpsc_pkg::RESET_CODE);

  // Wire mode is static configuration; resampled on the link clock
  arpsc_sync #(
    .W    (1),
    .INIT (1'b0)
  ) u_tw_sync (
    .clk (sclk),
    .rst (1'b0),
    .d   (three_wire_mode),
    .q   (tw_s)
  );

  // Bits are taken on falling serial clock; deselect clears the frame
  always_ff @(negedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      sh_q  <= 16'h0000;
      bit_q <= 4'h0;
      ones_q <= 11'h000;
      arm_q <= 1'b0;
    end
    else
    begin
      sh_q  <= frame_w;
      bit_q <= bit_q + 4'h1;
      // Ones run saturates at the longer pattern length
      if (sdi)
      begin
        if (ones_q != arpsc_pkg::PAT2_ONES)
          ones_q <= ones_q + 11'h001;
      end
      else
        ones_q <= 11'h000;
      // Four-wire only: pending reset fires when select rises
      if (!tw_s && ((sdi && ones_q >= arpsc_pkg::PAT1_ONES) || code_hit))
        arm_q <= 1'b1;
    end
  end

  // Event toggles survive deselect, so only power-on clears them
  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
    begin
      wr_tgl_q   <= 1'b0;
      pat_tgl_q  <= 1'b0;
      code_tgl_q <= 1'b0;
      wr_addr_q  <= 7'h00;
      wr_data_q  <= 8'h00;
    end
    else
    begin
      // Zero after a long run of ones resets in either wire mode
      if (!sdi && ones_q >= arpsc_pkg::PAT1_ONES)
        pat_tgl_q <= ~pat_tgl_q;
      if (code_hit && tw_s)
        code_tgl_q <= ~code_tgl_q;
      // Reset code is never stored; other writes go across
      if (wr_done && !code_hit)
      begin
        wr_addr_q <= frame_w[arpsc_pkg::ADDR_MSB:arpsc_pkg::ADDR_LSB];
        wr_data_q <= frame_w[arpsc_pkg::DATA_MSB:0];
        wr_tgl_q  <= ~wr_tgl_q;
      end
    end
  end

  // Pins and link events into the converter clock
  arpsc_sync #(
    .W    (11),
    .INIT (arpsc_pkg::SYNC_INIT)
  ) u_in_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   ({arm_q, code_tgl_q, pat_tgl_q, wr_tgl_q, supply_low, cs_n, reset_pin_n, start_pin}),
    .q   (sy_s)
  );

  assign {arm_s, code_s, pat_s, wr_s, sup_s, cs_s, rpin_s, start_s} = sy_s;
  assign start_rise = start_s & ~start_p_q;
  assign cs_rise    = cs_s & ~cs_p_q;
  assign wr_ev      = wr_s ^ wr_p_q;
  assign pat_ev     = pat_s ^ pat_p_q;
  assign code_ev    = code_s ^ code_p_q;
  assign any_rst    = rst | dev_rst_q;

  // Edge history; pending flag lags one more stage because deselect
  // clears it at the same instant select rises
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      start_p_q <= 1'b0;
      cs_p_q    <= 1'b1;
      wr_p_q    <= 1'b0;
      pat_p_q   <= 1'b0;
      code_p_q  <= 1'b0;
      arm_d_q   <= 1'b0;
    end
    else
    begin
      start_p_q <= start_s;
      cs_p_q    <= cs_s;
      wr_p_q    <= wr_s;
      pat_p_q   <= pat_s;
      code_p_q  <= code_s;
      arm_d_q   <= arm_s;
    end
  end

  // Device reset: pin low, code write, or pattern
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      dev_rst_q <= 1'b0;
    else
      dev_rst_q <= ~rpin_s | pat_ev | code_ev | (cs_rise & arm_d_q);
  end

  // User registers and command pulses; any reset restores defaults
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
    begin
      cfg2_q      <= arpsc_pkg::CFG2_RESET;
      mux_q       <= arpsc_pkg::MUX_RESET;
      start_cmd_q <= 1'b0;
      stop_cmd_q  <= 1'b0;
      restart_q   <= 1'b0;
    end
    else
    begin
      start_cmd_q <= 1'b0;
      stop_cmd_q  <= 1'b0;
      // Checksum registers are exempt from the restart
      restart_q   <= wr_ev && (wr_addr_q >= arpsc_pkg::ADDR_MUX)
                     && !((wr_addr_q >= arpsc_pkg::ADDR_CRC_LO)
                     && (wr_addr_q <= arpsc_pkg::ADDR_CRC_HI));
      if (wr_ev)
      begin
        case (wr_addr_q)
          arpsc_pkg::ADDR_CONTROL:
          begin
            // Commands ignored in synchronized mode
            if (mode_w != arpsc_pkg::SM_SYNC)
            begin
              start_cmd_q <= wr_data_q[arpsc_pkg::CTL_START];
              stop_cmd_q  <= wr_data_q[arpsc_pkg::CTL_STOP];
            end
          end
          arpsc_pkg::ADDR_MUX:
            mux_q <= wr_data_q;
          arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER:
            cfg2_q <= wr_data_q;
          default:
            ;
        endcase
      end
    end
  end

  // Status flags: set beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
    begin
      por_q <= 1'b1;
      alv_q <= 1'b1;
    end
    else
    begin
      if (wr_ev && wr_addr_q == arpsc_pkg::ADDR_STATUS && wr_data_q[arpsc_pkg::ST_POR])
        por_q <= 1'b0;
      if (|sup_s)
        alv_q <= 1'b1;
      else if (wr_ev && wr_addr_q == arpsc_pkg::ADDR_STATUS && wr_data_q[arpsc_pkg::ST_ALV])
        alv_q <= 1'b0;
    end
  end

  assign mode_w  = arpsc_pkg::arpsc_start_mode_t'(cfg2_q[arpsc_pkg::CFG_MODE_LSB +: 2]);
  assign power_off_bit_w  = cfg2_q[arpsc_pkg::CFG_POWER_OFF_BIT];
  assign stby_w  = cfg2_q[arpsc_pkg::CFG_STBY];
  assign trig_w  = start_rise | start_cmd_q;
  assign done_w  = (state_q != arpsc_pkg::ST_STOP) && (cnt_q == 16'h0001);
  // Skip when the edge lands a whole number of periods on, within one clock;
  // ph_q reads one less than the cycles since the sync, so a whole period
  // shows as the top count and the window sits either side of it
  assign resync_w = (mode_w == arpsc_pkg::SM_SYNC) && start_rise
                    && !(have_sync_q && ((ph_q < arpsc_pkg::SYNC_WIN_CYC)
                    || (ph_q >= arpsc_pkg::CONV_PERIOD_CYC - 16'h0001
                                - arpsc_pkg::SYNC_WIN_CYC)));
  // Start/stop mode runs while pin or command latch is high
  assign go_w    = start_s | ss_run_q;
  // Latency of a first conversion; longer coming out of standby
  assign lat_w   = (state_q == arpsc_pkg::ST_STOP && stby_w)
                   ? arpsc_pkg::FILTER_LAT_CYC + arpsc_pkg::STBY_EXTRA_CYC
                   : arpsc_pkg::FILTER_LAT_CYC;

  // Command latch for start/stop mode
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      ss_run_q <= 1'b0;
    else if (start_cmd_q)
      ss_run_q <= 1'b1;
    else if (stop_cmd_q || !start_s && start_p_q)
      ss_run_q <= 1'b0;
  end

  // Phase of sync-mode edges against the conversion period
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
    begin
      ph_q        <= 16'h0000;
      have_sync_q <= 1'b0;
    end
    else if (resync_w)
    begin
      ph_q        <= 16'h0000;
      have_sync_q <= 1'b1;
    end
    else if (ph_q == arpsc_pkg::CONV_PERIOD_CYC - 16'h0001)
      ph_q <= 16'h0000;
    else
      ph_q <= ph_q + 16'h0001;
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
    begin
      state_q  <= arpsc_pkg::ST_STOP;
      cnt_q    <= 16'h0000;
      conversion_ready_n_n_q <= 1'b1;
    end
    else if (power_off_bit_w)
    begin
      // Power-off halts the sequencer; registers stay
      state_q <= arpsc_pkg::ST_STOP;
      cnt_q   <= 16'h0000;
    end
    else
    begin
      case (state_q)
        arpsc_pkg::ST_STOP:
        begin
          // Sync mode free-runs; one-shot waits for a trigger
          if ((mode_w == arpsc_pkg::SM_SYNC)
              || (mode_w == arpsc_pkg::SM_ONESHOT && trig_w)
              || (mode_w != arpsc_pkg::SM_SYNC && mode_w != arpsc_pkg::SM_ONESHOT
                  && go_w))
          begin
            state_q  <= arpsc_pkg::ST_SETTLE;
            cnt_q    <= lat_w;
            conversion_ready_n_n_q <= 1'b1;
          end
        end
        arpsc_pkg::ST_SETTLE, arpsc_pkg::ST_RUN:
        begin
          if (restart_q || resync_w || (mode_w != arpsc_pkg::SM_SYNC && trig_w))
          begin
            // Restart discards the conversion in progress
            state_q  <= arpsc_pkg::ST_SETTLE;
            cnt_q    <= lat_w;
            conversion_ready_n_n_q <= 1'b1;
          end
          else if (done_w)
          begin
            conversion_ready_n_n_q <= 1'b0;
            // Stop requests take effect only at a result
            if (mode_w == arpsc_pkg::SM_ONESHOT
                || (mode_w != arpsc_pkg::SM_SYNC && !go_w))
              state_q <= arpsc_pkg::ST_STOP;
            else
            begin
              state_q <= arpsc_pkg::ST_RUN;
              cnt_q   <= arpsc_pkg::CONV_PERIOD_CYC;
            end
          end
          else
          begin
            cnt_q <= cnt_q - 16'h0001;
            // Short high pulse ahead of the next result
            if (state_q == arpsc_pkg::ST_RUN && cnt_q == 16'h0002)
              conversion_ready_n_n_q <= 1'b1;
          end
        end
        default:
          state_q <= arpsc_pkg::ST_STOP;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sampling_on   <= 1'b1;
      filter_active <= 1'b0;
      standby_on    <= 1'b0;
      sdo           <= 1'b1;
    end
    else
    begin
      // Idle keeps sampling; standby and power-off stop it
      sampling_on   <= !power_off_bit_w && !(state_q == arpsc_pkg::ST_STOP && stby_w);
      filter_active <= !power_off_bit_w && state_q != arpsc_pkg::ST_STOP;
      standby_on    <= !power_off_bit_w && state_q == arpsc_pkg::ST_STOP && stby_w;
      sdo           <= conversion_ready_n_n_q;
    end
  end

  assign conversion_ready_n       = conversion_ready_n_n_q;
  assign second_config_register   = cfg2_q;
  assign input_selector_register  = mux_q;
  assign por_flag                 = por_q;
  assign analog_undervoltage_flag = alv_q;
  assign device_reset             = dev_rst_q;

  // Checks
  a_reset_sets_por: assert property (@(posedge sys_clk) disable iff (rst)
    dev_rst_q |=> por_q) else $error("por flag not set by reset");
  a_por_sets_alv: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(por_q) |-> alv_q) else $error("alv not set with por");
  a_supply_sets_alv: assert property (@(posedge sys_clk) disable iff (rst)
    (|sup_s) |=> alv_q) else $error("alv missed supply low");
  a_pattern_resets: assert property (@(posedge sys_clk) disable iff (rst)
    (pat_ev || code_ev || (cs_rise && arm_d_q)) |=> dev_rst_q ##1 cfg2_q == arpsc_pkg::CFG2_RESET)
    else $error("serial reset not taken");
  a_pin_reset: assert property (@(posedge sys_clk) disable iff (rst)
    !rpin_s |=> dev_rst_q ##1 state_q == arpsc_pkg::ST_STOP) else $error("pin reset lost");
  a_power_off_bit_halts: assert property (@(posedge sys_clk) disable iff (rst)
    power_off_bit_w && !dev_rst_q |=> state_q == arpsc_pkg::ST_STOP ##1 !filter_active)
    else $error("power-off did not halt");
  a_stby_latency: assert property (@(posedge sys_clk) disable iff (rst)
    state_q == arpsc_pkg::ST_STOP && stby_w && !power_off_bit_w && !any_rst
    ##1 state_q == arpsc_pkg::ST_SETTLE
    |-> cnt_q == arpsc_pkg::FILTER_LAT_CYC + arpsc_pkg::STBY_EXTRA_CYC)
    else $error("standby latency wrong");
  a_sync_free_run: assert property (@(posedge sys_clk) disable iff (rst)
    mode_w == arpsc_pkg::SM_SYNC && !power_off_bit_w && !any_rst && state_q == arpsc_pkg::ST_STOP
    |=> state_q == arpsc_pkg::ST_SETTLE) else $error("sync mode not converting");
  a_oneshot_single: assert property (@(posedge sys_clk) disable iff (rst)
    mode_w == arpsc_pkg::SM_ONESHOT && done_w && !trig_w && !restart_q && !power_off_bit_w
    && !any_rst |=> state_q == arpsc_pkg::ST_STOP && !conversion_ready_n_n_q)
    else $error("one-shot did not stop");
  a_write_restart: assert property (@(posedge sys_clk) disable iff (rst)
    restart_q && !power_off_bit_w && !dev_rst_q && state_q != arpsc_pkg::ST_STOP
    |=> state_q == arpsc_pkg::ST_SETTLE && cnt_q == arpsc_pkg::FILTER_LAT_CYC)
    else $error("write did not restart");
  a_ones_clear: assert property (@(negedge sclk) disable iff (frame_rst)
    !sdi |=> ones_q == 11'h000) else $error("ones run not cleared");
  c_pattern_reset: cover property (@(posedge sys_clk) disable iff (rst) pat_ev);
  c_resync_skip: cover property (@(posedge sys_clk) disable iff (rst)
    start_rise && mode_w == arpsc_pkg::SM_SYNC && !resync_w);
  c_oneshot_done: cover property (@(posedge sys_clk) disable iff (rst)
    mode_w == arpsc_pkg::SM_ONESHOT && done_w);
endmodule
`default_nettype wire

// ==== arpsc_host.sv ====
// Host model: serial port master plus start and reset pins
`default_nettype none
module arpsc_host (
  output var logic sclk,
  output var logic cs_n,
  output var logic sdi,
  output var logic start_pin,
  output var logic reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels; sclk stands low outside frames, start low under commands
  initial
  begin
    sclk = 1'b0;
    // Select starts low so the bench's reset edge clears the frame logic
    cs_n = 1'b0;
    sdi = 1'b0;
    start_pin = 1'b0;
    reset_pin_n = 1'b1;
    #2 cs_n = 1'b1;
  end
  // One bit at 64 ns: changed on rising edge, taken on falling edge
  task automatic put_bit(input logic b);
    sclk = 1'b1;
    sdi = b;
    #32 sclk = 1'b0;
    #32;
  endtask
  // Write frame, MSB first; the released data line flips so no stale value lingers
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {1'b0, a, d};
    cs_n = 1'b0;
    #64;
    for (int i = 15; i >= 0; i--)
      put_bit(f[i]);
    #64 cs_n = 1'b1;
    sdi = ~sdi;
    #1000;
  endtask
  // Long run of ones, optional closing zero, then select released
  task automatic pattern(input int ones, input logic tail);
    cs_n = 1'b0;
    #64;
    repeat (ones)
      put_bit(1'b1);
    if (tail)
      put_bit(1'b0);
    #64 cs_n = 1'b1;
    sdi = ~sdi;
    #1000;
  endtask
  // Pin reset: low, then back high
  task automatic pulse_reset();
    reset_pin_n = 1'b0;
    #500 reset_pin_n = 1'b1;
  endtask
  task automatic set_start(input logic v);
    start_pin = v;
  endtask
endmodule
`default_nettype wire

// ==== arpsc_ctrl_test.sv ====
// Self-checking bench for the converter reset and power control block
`default_nettype none
module arpsc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b0;
  logic       three_wire_mode = 1'b0;
  logic       sdo, device_reset;
  logic [3:0] supply_low = 4'h0;
  logic       sclk, cs_n, sdi, start_pin, reset_pin_n;
  logic       conversion_ready_n, por_flag, analog_undervoltage_flag;
  logic       sampling_on, filter_active, standby_on;
  logic [7:0] second_config_register, input_selector_register;
  int         errors = 0;
  int         cmp_count = 0;
  int         n, m, lat[2];
  // Converter clock, 100 ns
  always #50 sys_clk = ~sys_clk;
  arpsc_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .start_pin(start_pin),
    .reset_pin_n(reset_pin_n));
  // Four-wire unless a case selects three-wire; pattern 2 needs select edges
  arpsc_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .three_wire_mode(three_wire_mode), .start_pin(start_pin), .reset_pin_n(reset_pin_n),
    .supply_low(supply_low), .sdo(sdo), .conversion_ready_n(conversion_ready_n),
    .second_config_register(second_config_register),
    .input_selector_register(input_selector_register), .por_flag(por_flag),
    .analog_undervoltage_flag(analog_undervoltage_flag), .sampling_on(sampling_on),
    .filter_active(filter_active), .standby_on(standby_on), .device_reset(device_reset));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input int lo, input int hi, input int g);
    cmp_count++;
    if (g < lo || g > hi)
    begin
      errors++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Inputs move 1 ns after the rising edge; outputs are settled there
  task automatic tick(input int k);
    repeat (k)
      @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    tick(8);
  endtask
  // Cycles to the next ready falling edge; a hang ends the run
  task automatic wait_fall(output int c);
    logic p;
    c = 0;
    p = 1'b0;
    while (!(p === 1'b1 && conversion_ready_n === 1'b0))
    begin
      p = conversion_ready_n;
      tick(1);
      c++;
      if (c > 400)
      begin
        errors++;
        final_report();
      end
    end
  endtask
  initial
  begin
    // Reset rises just after time zero so the link-side clears see an edge
    #1 rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    chk("cfg2", arpsc_pkg::CFG2_RESET, second_config_register);
    chk("selector", arpsc_pkg::MUX_RESET, input_selector_register);
    chk("por", 8'h01, {7'h0, por_flag});
    chk("alv", 8'h01, {7'h0, analog_undervoltage_flag});
    chk("ready_n", 8'h01, {7'h0, conversion_ready_n});
    chk("sdo", 8'h01, {7'h0, sdo});
    chk("dev reset", 8'h00, {7'h0, device_reset});
    $display("test defaults done");
    wr(arpsc_pkg::ADDR_STATUS, 8'h03);
    chk("por", 8'h00, {7'h0, por_flag});
    chk("alv", 8'h00, {7'h0, analog_undervoltage_flag});
    for (int i = 0; i < 4; i++)
    begin
      supply_low[i] = 1'b1;
      tick(4);
      supply_low = 4'h0;
      tick(4);
      chk("alv", 8'h01, {7'h0, analog_undervoltage_flag});
      wr(arpsc_pkg::ADDR_STATUS, 8'h02);
      chk("alv", 8'h00, {7'h0, analog_undervoltage_flag});
    end
    $display("test flags done");
    for (int s = 0; s < 4; s++)
    begin
      wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, 8'h04 | 8'(s));
      chk("cfg2", 8'h04 | 8'(s), second_config_register);
    end
    wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, 8'h24);
    chk("sampling", 8'h00, {7'h0, sampling_on});
    wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, 8'h04);
    chk("sampling", 8'h01, {7'h0, sampling_on});
    $display("test modes done");
    // One-shot from idle, then from standby; start drops mid-conversion
    for (int k = 0; k < 2; k++)
    begin
      wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, (k == 1) ? 8'h18 : 8'h08);
      chk("standby", 8'(k), {7'h0, standby_on});
      chk("sampling", 8'(1 - k), {7'h0, sampling_on});
      host.set_start(1'b1);
      tick(10);
      host.set_start(1'b0);
      chk("filter", 8'h01, {7'h0, filter_active});
      chk("sampling", 8'h01, {7'h0, sampling_on});
      wait_fall(m);
      lat[k] = m + 10;
      tick(2);
      chk("filter", 8'h00, {7'h0, filter_active});
      chk("sdo", 8'h00, {7'h0, sdo});
    end
    chk_in("latency", 76, 82, lat[0]);
    chk_in("standby extra", 24, 24, lat[1] - lat[0]);
    $display("test one-shot done");
    wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, 8'h04);
    host.set_start(1'b1);
    wait_fall(n);
    wait_fall(n);
    chk_in("period", 20, 20, n);
    wr(arpsc_pkg::ADDR_MUX, 8'h05);
    wait_fall(n);
    chk_in("selector restart", 40, 80, n);
    chk("selector", 8'h05, input_selector_register);
    wr(arpsc_pkg::ADDR_CRC_LO, 8'h3C);
    wait_fall(n);
    chk_in("checksum no restart", 1, 20, n);
    host.set_start(1'b0);
    tick(30);
    chk("filter", 8'h00, {7'h0, filter_active});
    wr(arpsc_pkg::ADDR_CONTROL, 8'h01);
    wait_fall(n);
    chk_in("command start", 1, 90, n);
    wr(arpsc_pkg::ADDR_CONTROL, 8'h02);
    tick(30);
    chk("filter", 8'h00, {7'h0, filter_active});
    $display("test start-stop done");
    // Leaving the stopped state in sync mode pays the filter latency first
    wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, 8'h00);
    wait_fall(n);
    m = int'(arpsc_pkg::FILTER_LAT_CYC);
    chk_in("sync start", m - 20, m - 10, n);
    wait_fall(n);
    chk_in("free run", 20, 20, n);
    host.set_start(1'b1);
    tick(5);
    host.set_start(1'b0);
    wait_fall(n);
    chk_in("sync latency", 76, 82, n + 5);
    tick(95 - n);
    host.set_start(1'b1);
    tick(5);
    host.set_start(1'b0);
    wait_fall(m);
    chk_in("no resync", 1, 21, m + 5);
    // Edge one clock early against the period must not resync either
    tick(20);
    host.set_start(1'b1);
    tick(5);
    host.set_start(1'b0);
    wait_fall(m);
    chk_in("early edge no resync", 1, 21, m + 5);
    $display("test sync done");
    // Even cases and the three-wire code write (case 7) reset; cases 1, 3 and 5 are near misses
    for (int i = 0; i < 8; i++)
    begin
      wr(arpsc_pkg::ADDR_SECOND_CONFIG_REGISTER, 8'h05);
      wr(arpsc_pkg::ADDR_STATUS, 8'h03);
      three_wire_mode = (i == 7);
      case (i)
        0: host.write_reg(arpsc_pkg::ADDR_CONTROL, arpsc_pkg::RESET_CODE);
        1: host.write_reg(arpsc_pkg::ADDR_CONTROL, 8'h5C);
        2: host.pattern(1023, 1'b1);
        3: host.pattern(1022, 1'b1);
        4: host.pattern(1024, 1'b0);
        5: host.pattern(1023, 1'b0);
        7: host.write_reg(arpsc_pkg::ADDR_CONTROL, arpsc_pkg::RESET_CODE);
        default:
          fork
            host.pulse_reset();
            begin
              tick(4);
              chk("dev reset", 8'h01, {7'h0, device_reset});
            end
          join
      endcase
      tick(8);
      chk("por", 8'(i % 2 == 0 || i == 7), {7'h0, por_flag});
      chk("cfg2", (i % 2 == 0 || i == 7) ? 8'h04 : 8'h05, second_config_register);
      chk("dev reset", 8'h00, {7'h0, device_reset});
    end
    $display("test resets done");
    final_report();
  end
endmodule
`default_nettype wire
